/* core/ism_regs.vh */
// Purpose: Register map, field positions, reset values and timing counts
//          of the two-wire bus status, mask and enable block.
// Assumes: 16-bit register port, 3-bit word address.
// Notes:   Definitions only.
`ifndef ISM_REGS_VH
`define ISM_REGS_VH

// ----
// Register addresses
// ----
`define ISM_A_CTRL 3'h0
`define ISM_A_STAT 3'h1
`define ISM_A_MASK 3'h2
`define ISM_A_OWN 3'h3
`define ISM_A_TRN 3'h4
`define ISM_A_RCV 3'h5

// ----
// Control register fields
// ----
`define ISM_C_EN 15
`define ISM_C_A10 10
`define ISM_C_PEN 2
`define ISM_C_SEN 0
`define ISM_C_WMASK 16'h8405
`define ISM_C_LOWMASK 16'h001f

// ----
// Status register fields
// ----
`define ISM_S_WCOL 7
`define ISM_S_ROV 6
`define ISM_S_DA 5
`define ISM_S_STOP 4
`define ISM_S_START 3
`define ISM_S_RW 2
`define ISM_S_RBF 1
`define ISM_S_TBF 0

// ----
// Reset values
// ----
`define ISM_RST_CTRL 16'h0000
`define ISM_RST_MASK 10'h000
`define ISM_RST_OWN 10'h000
`define ISM_RST_BYTE 8'h00

// ----
// Timing
// ----
`define ISM_CLK_MHZ 50
`define ISM_T_HALF_NS 5000
`define ISM_HALF_CYC ((`ISM_T_HALF_NS * `ISM_CLK_MHZ) / 1000)

`endif

/* core/ism_busmon.v */
// Purpose: Synchronise the bus pins and detect Start, Stop and clock edges.
// Assumes: Pins are asynchronous to clk_sys; bus clock is slow against it.
// Notes:   Event outputs are one-cycle pulses.
`timescale 1ns/1ns

module ism_busmon (
    input wire clk_sys,       // System clock
    input wire sys_rst,       // Synchronous reset, active high
    input wire scl_in,        // Serial clock pin level
    input wire sda_in,        // Serial data pin level
    output reg scl_s_ff,      // Synchronised clock level
    output reg sda_s_ff,      // Synchronised data level
    output reg start_ff,      // Start or repeated Start seen
    output reg stop_ff,       // Stop seen
    output reg rise_ff,       // Clock rising edge
    output reg fall_ff        // Clock falling edge
);

    reg scl_m_ff;
    reg sda_m_ff;
    reg scl_p_ff;
    reg sda_p_ff;

    // ------------------------------------------------------------
    // Two-stage sync, then edge compare on the settled stages
    // ------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            scl_m_ff <= 1'b1;
            sda_m_ff <= 1'b1;
            scl_s_ff <= 1'b1;
            sda_s_ff <= 1'b1;
            scl_p_ff <= 1'b1;
            sda_p_ff <= 1'b1;
            start_ff <= 1'b0;
            stop_ff <= 1'b0;
            rise_ff <= 1'b0;
            fall_ff <= 1'b0;
        end else begin
            scl_m_ff <= scl_in;
            sda_m_ff <= sda_in;
            scl_s_ff <= scl_m_ff;
            sda_s_ff <= sda_m_ff;
            scl_p_ff <= scl_s_ff;
            sda_p_ff <= sda_s_ff;
            start_ff <= scl_s_ff & scl_p_ff & sda_p_ff & ~sda_s_ff;
            stop_ff <= scl_s_ff & scl_p_ff & ~sda_p_ff & sda_s_ff;
            rise_ff <= scl_s_ff & ~scl_p_ff;
            fall_ff <= ~scl_s_ff & scl_p_ff;
        end
    end

endmodule

/* core/ism_core.v */
// Purpose: Status flags, slave address masking and module enable of a
//          two-wire serial bus controller with master and slave engines.
// Assumes: Open-drain pins; bus clock far slower than clk_sys.
// Notes:   Registers on a plain port, read data one cycle after the strobe.
//
// Overview of operation
// RL1: Transmit buffer write while busy is dropped and sets write collision flag.
// RL2: Receive buffer still full when a new byte lands sets overflow flag.
// RL3: Data/address flag clears on address match, sets on data rx or tx done.
// RL4: Start sets start flag, clears stop flag; Stop does the reverse.
// RL5: Direction flag takes the read/write bit of the slave address byte.
// RL6: Receive-full sets when buffer loaded, clears when software reads it.
// RL7: Transmit-full sets on buffer write, clears when that byte is sent.
// RL8: Ten-bit addressing: mask bit one ignores that address bit.
// RL9: Seven-bit addressing: mask bit x governs incoming address bit x+1.
// RL10: Mask has ten read/write bits reset to zero; upper six read zero.
// RL11: Control top bit enables the whole module.
// RL12: When enabled, master and slave engines run at the same time.
// RL13: On enabling, both pins are released leaving the bus idle.
// RL14: Master waits for start enable and a transmit buffer load.
// RL15: Slave watches the bus always, answering Start plus matching address; the code holds the slave idle while the module is disabled.
// RL16: Start enable bit clears itself when the generated Start completes.
// RL17: Software writes zero to clear collision and overflow; set wins.
`timescale 1ns/1ns
`include "ism_regs.vh"

module ism_core #(
    parameter HALF_CYC = `ISM_HALF_CYC // Bus clock half period in cycles
) (
    input wire clk_sys,            // System clock
    input wire sys_rst,            // Synchronous reset, active high
    input wire [2:0] reg_addr,     // Register word address
    input wire [15:0] reg_wdata,   // Write data
    input wire reg_wr,             // Write strobe
    input wire reg_rd,             // Read strobe
    output reg [15:0] reg_rdata_ff, // Read data, cycle after strobe
    input wire scl_in,             // Serial clock pin level
    input wire sda_in,             // Serial data pin level
    output reg scl_out_ff,         // Serial clock drive value
    output reg scl_oe_ff,          // Serial clock pulled low when high
    output reg sda_out_ff,         // Serial data drive value
    output reg sda_oe_ff           // Serial data pulled low when high
);

    localparam M_IDLE = 3'd0;
    localparam M_ST1 = 3'd1;
    localparam M_ST2 = 3'd2;
    localparam M_HOLD = 3'd3;
    localparam M_TXL = 3'd4;
    localparam M_TXH = 3'd5;
    localparam M_SP1 = 3'd6;
    localparam M_SP2 = 3'd7;

    localparam S_IDLE = 2'd0;
    localparam S_ADDR = 2'd1;
    localparam S_RX = 2'd2;
    localparam S_TX = 2'd3;

    localparam [15:0] HALF = HALF_CYC;

    // Masked compare; a set mask bit drops that position from the test
    function match;
        input [9:0] got;
        input [9:0] own;
        input [9:0] msk;
        begin
            match = ((got ^ own) & ~msk) == 10'h000;
        end
    endfunction

    reg [15:0] ctrl_ff;
    reg [9:0] mask_ff;
    reg [9:0] own_ff;
    reg [7:0] trn_ff;
    reg [7:0] rcv_ff;
    reg wcol_ff, rov_ff, da_ff, stp_ff, sta_ff, rw_ff, rbf_ff, tbf_ff;
    reg [2:0] m_st_ff;
    reg [15:0] tmr_ff;
    reg [3:0] m_cnt_ff;
    reg [8:0] m_sh_ff;
    reg m_scl_ff, m_sda_ff;
    reg [1:0] s_st_ff;
    reg [3:0] s_cnt_ff;
    reg [7:0] s_sh_ff;
    reg s_ack_ff, s_sda_ff, ten_hi_ff, ten_ok_ff;
    wire scl_s, sda_s, bus_start, bus_stop, scl_rise, scl_fall;

    wire en = ctrl_ff[`ISM_C_EN];
    wire tmr_done = tmr_ff == 16'h0000;
    wire m_busy = (m_st_ff != M_IDLE) && (m_st_ff != M_HOLD);
    wire wr_trn = reg_wr && reg_addr == `ISM_A_TRN;
    wire trn_busy = m_busy || tbf_ff || ctrl_ff[`ISM_C_SEN];
    wire [15:0] stat = {8'h00, wcol_ff, rov_ff, da_ff, stp_ff, sta_ff, rw_ff, rbf_ff, tbf_ff};
    wire hit7 = match({3'b000, s_sh_ff[7:1]}, {3'b000, own_ff[6:0]}, {3'b000, mask_ff[6:0]});
    wire hit10h = s_sh_ff[7:3] == 5'b11110 &&
                  match({8'h00, s_sh_ff[2:1]}, {8'h00, own_ff[9:8]}, {8'h00, mask_ff[9:8]});
    wire hit10l = match({2'b00, s_sh_ff}, {2'b00, own_ff[7:0]}, {2'b00, mask_ff[7:0]});

    ism_busmon u_mon (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .scl_s_ff(scl_s),
        .sda_s_ff(sda_s),
        .start_ff(bus_start),
        .stop_ff(bus_stop),
        .rise_ff(scl_rise),
        .fall_ff(scl_fall)
    );

    // ------------------------------------------------------------
    // Register port, flags and both engines
    // ------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            ctrl_ff <= `ISM_RST_CTRL;
            mask_ff <= `ISM_RST_MASK;
            own_ff <= `ISM_RST_OWN;
            trn_ff <= `ISM_RST_BYTE;
            rcv_ff <= `ISM_RST_BYTE;
            {wcol_ff, rov_ff, da_ff, stp_ff, sta_ff, rw_ff, rbf_ff, tbf_ff} <= 8'h00;
            reg_rdata_ff <= 16'h0000;
            m_st_ff <= M_IDLE;
            tmr_ff <= 16'h0000;
            m_cnt_ff <= 4'h0;
            m_sh_ff <= 9'h1ff;
            m_scl_ff <= 1'b0;
            m_sda_ff <= 1'b0;
            s_st_ff <= S_IDLE;
            s_cnt_ff <= 4'h0;
            s_sh_ff <= 8'h00;
            s_ack_ff <= 1'b0;
            s_sda_ff <= 1'b0;
            ten_hi_ff <= 1'b0;
            ten_ok_ff <= 1'b0;
        end else begin
            // Register reads
            reg_rdata_ff <= 16'h0000;
            if (reg_rd) begin
                case (reg_addr)
                    `ISM_A_CTRL: reg_rdata_ff <= ctrl_ff;
                    `ISM_A_STAT: reg_rdata_ff <= stat;
                    `ISM_A_MASK: reg_rdata_ff <= {6'h00, mask_ff}; // see RL10
                    `ISM_A_OWN: reg_rdata_ff <= {6'h00, own_ff};
                    `ISM_A_TRN: reg_rdata_ff <= {8'h00, trn_ff};
                    `ISM_A_RCV: reg_rdata_ff <= {8'h00, rcv_ff};
                    default: reg_rdata_ff <= 16'h0000;
                endcase
                if (reg_addr == `ISM_A_RCV)
                    rbf_ff <= 1'b0; // see RL6
            end

            // Register writes; hardware sets further down override clears
            if (reg_wr) begin
                case (reg_addr)
                    `ISM_A_CTRL: begin
                        // Low control bits locked while a Start is running
                        if (m_st_ff == M_ST1 || m_st_ff == M_ST2)
                            ctrl_ff <= (ctrl_ff & `ISM_C_LOWMASK) | (reg_wdata & `ISM_C_WMASK & ~`ISM_C_LOWMASK);
                        else
                            ctrl_ff <= reg_wdata & `ISM_C_WMASK; // see RL11
                    end
                    `ISM_A_STAT: begin
                        if (!reg_wdata[`ISM_S_WCOL])
                            wcol_ff <= 1'b0; // see RL17
                        if (!reg_wdata[`ISM_S_ROV])
                            rov_ff <= 1'b0; // see RL17
                    end
                    `ISM_A_MASK: mask_ff <= reg_wdata[9:0]; // see RL10
                    `ISM_A_OWN: own_ff <= reg_wdata[9:0];
                    default: begin
                    end
                endcase
            end
            if (wr_trn) begin
                if (trn_busy) begin
                    wcol_ff <= 1'b1; // see RL1
                end else begin
                    trn_ff <= reg_wdata[7:0];
                    tbf_ff <= 1'b1; // see RL7
                end
            end

            // Master engine; runs beside the slave engine (see RL12)
            if (tmr_ff != 16'h0000)
                tmr_ff <= tmr_ff - 16'h0001;
            case (m_st_ff)
                M_IDLE: begin
                    m_scl_ff <= 1'b0;
                    m_sda_ff <= 1'b0;
                    if (en && ctrl_ff[`ISM_C_SEN]) begin // see RL14
                        m_sda_ff <= 1'b1;
                        tmr_ff <= HALF;
                        m_st_ff <= M_ST1;
                    end
                end
                M_ST1: if (tmr_done) begin
                    m_scl_ff <= 1'b1;
                    tmr_ff <= HALF;
                    m_st_ff <= M_ST2;
                end
                M_ST2: if (tmr_done) begin
                    ctrl_ff[`ISM_C_SEN] <= 1'b0; // see RL16
                    m_st_ff <= M_HOLD;
                end
                M_HOLD: begin
                    if (tbf_ff) begin // see RL14
                        m_sh_ff <= {trn_ff[6:0], 2'b11};
                        m_sda_ff <= ~trn_ff[7];
                        m_cnt_ff <= 4'h0;
                        tmr_ff <= HALF;
                        m_st_ff <= M_TXL;
                    end else if (ctrl_ff[`ISM_C_PEN]) begin
                        m_sda_ff <= 1'b1;
                        tmr_ff <= HALF;
                        m_st_ff <= M_SP1;
                    end
                end
                M_TXL: if (tmr_done) begin
                    m_scl_ff <= 1'b0;
                    tmr_ff <= HALF;
                    m_st_ff <= M_TXH;
                end
                M_TXH: if (tmr_done) begin
                    m_scl_ff <= 1'b1;
                    tmr_ff <= HALF;
                    if (m_cnt_ff == 4'h8) begin
                        m_sda_ff <= 1'b0;
                        tbf_ff <= 1'b0; // see RL7
                        m_st_ff <= M_HOLD;
                    end else begin
                        m_sda_ff <= ~m_sh_ff[8];
                        m_sh_ff <= {m_sh_ff[7:0], 1'b1};
                        m_cnt_ff <= m_cnt_ff + 4'h1;
                        m_st_ff <= M_TXL;
                    end
                end
                M_SP1: if (tmr_done) begin
                    m_scl_ff <= 1'b0;
                    tmr_ff <= HALF;
                    m_st_ff <= M_SP2;
                end
                M_SP2: if (tmr_done) begin
                    m_sda_ff <= 1'b0;
                    ctrl_ff[`ISM_C_PEN] <= 1'b0;
                    m_st_ff <= M_IDLE;
                end
                default: m_st_ff <= M_IDLE;
            endcase

            // Bus condition flags
            if (bus_start) begin
                sta_ff <= 1'b1; // see RL4
                stp_ff <= 1'b0;
            end
            if (bus_stop) begin
                stp_ff <= 1'b1; // see RL4
                sta_ff <= 1'b0;
            end

            // Slave engine; watches the bus even with the master active
            if (bus_start) begin // see RL15
                s_st_ff <= S_ADDR;
                s_cnt_ff <= 4'h0;
                s_ack_ff <= 1'b0;
                s_sda_ff <= 1'b0;
                ten_hi_ff <= 1'b0;
            end else if (bus_stop) begin
                s_st_ff <= S_IDLE;
                s_sda_ff <= 1'b0;
                ten_ok_ff <= 1'b0;
            end else if (s_st_ff != S_IDLE) begin
                if (scl_rise && s_cnt_ff != 4'h8) begin
                    s_sh_ff <= {s_sh_ff[6:0], sda_s};
                    s_cnt_ff <= s_cnt_ff + 4'h1;
                end
                if (scl_rise && s_ack_ff && s_st_ff == S_TX && sda_s)
                    s_st_ff <= S_IDLE; // Master NACK ends slave send
                if (scl_fall && s_cnt_ff == 4'h8 && s_ack_ff) begin
                    s_ack_ff <= 1'b0;
                    s_cnt_ff <= 4'h0;
                    s_sda_ff <= 1'b0;
                    if (s_st_ff == S_TX || (s_st_ff == S_ADDR && rw_ff && !ten_hi_ff)) begin
                        s_st_ff <= S_TX;
                        s_sh_ff <= {trn_ff[6:0], 1'b1};
                        s_sda_ff <= ~trn_ff[7];
                    end else if (s_st_ff == S_ADDR && !ten_hi_ff) begin
                        s_st_ff <= S_RX;
                    end
                end else if (scl_fall && s_st_ff == S_TX && s_cnt_ff != 4'h8) begin
                    s_sda_ff <= ~s_sh_ff[7];
                    s_sh_ff <= {s_sh_ff[6:0], 1'b1};
                end else if (scl_fall && s_cnt_ff == 4'h8) begin
                    s_ack_ff <= 1'b1;
                    case (s_st_ff)
                        S_ADDR: begin
                            if (ctrl_ff[`ISM_C_A10] && ten_hi_ff) begin
                                if (hit10l) begin // see RL8
                                    s_sda_ff <= 1'b1;
                                    ten_hi_ff <= 1'b0;
                                    ten_ok_ff <= 1'b1;
                                    da_ff <= 1'b0; // see RL3
                                end else begin
                                    s_st_ff <= S_IDLE;
                                end
                            end else if (ctrl_ff[`ISM_C_A10] ? (hit10h && (!s_sh_ff[0] || ten_ok_ff)) : hit7) begin
                                s_sda_ff <= 1'b1; // see RL9
                                rw_ff <= s_sh_ff[0]; // see RL5
                                da_ff <= 1'b0; // see RL3
                                ten_hi_ff <= ctrl_ff[`ISM_C_A10] && !s_sh_ff[0];
                            end else begin
                                s_st_ff <= S_IDLE;
                            end
                        end
                        S_RX: begin
                            if (rbf_ff) begin
                                rov_ff <= 1'b1; // see RL2
                            end else begin
                                rcv_ff <= s_sh_ff;
                                rbf_ff <= 1'b1; // see RL6
                                s_sda_ff <= 1'b1;
                            end
                            da_ff <= 1'b1; // see RL3
                        end
                        S_TX: begin
                            s_sda_ff <= 1'b0;
                            tbf_ff <= 1'b0; // see RL7
                            da_ff <= 1'b1; // see RL3
                        end
                        default: s_st_ff <= S_IDLE;
                    endcase
                end
            end

            // Disabled module holds both engines idle
            if (!en) begin
                m_st_ff <= M_IDLE;
                m_scl_ff <= 1'b0;
                m_sda_ff <= 1'b0;
                s_st_ff <= S_IDLE;
                s_sda_ff <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Pin drivers: open drain, low only while enabled
    // ------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            scl_out_ff <= 1'b0;
            sda_out_ff <= 1'b0;
            scl_oe_ff <= 1'b0;
            sda_oe_ff <= 1'b0;
        end else begin
            scl_out_ff <= 1'b0;
            sda_out_ff <= 1'b0;
            scl_oe_ff <= en & m_scl_ff; // see RL13
            sda_oe_ff <= en & (m_sda_ff | s_sda_ff); // see RL13
        end
    end

endmodule

/* verif/ism_props.sv */
// Purpose: Properties on the ports of the two-wire status/mask core.
// Assumes: Open-drain wires with pull-ups; slow bus against clk_sys.
// Notes:   Helper flops mirror enable, mask and last bus condition.
`timescale 1ns/1ns
`include "ism_regs.vh"
module ism_props #(
    parameter HALF_CYC = 8 // Bus clock half period
) (
    input wire clk_sys, // System clock
    input wire sys_rst, // Reset
    input wire [2:0] reg_addr, // Address
    input wire [15:0] reg_wdata, // Write data
    input wire reg_wr, // Write strobe
    input wire reg_rd, // Read strobe
    input wire [15:0] reg_rdata_ff, // Read data
    input wire scl_in, // Clock pin
    input wire sda_in, // Data pin
    input wire scl_out_ff, // Clock drive value
    input wire scl_oe_ff, // Clock pull low
    input wire sda_out_ff, // Data drive value
    input wire sda_oe_ff // Data pull low
);
    reg en_ff, scl_p_ff, sda_p_ff, seen_ff, last_start_ff;
    reg [2:0] dis_cnt_ff;
    reg [3:0] age_ff;
    reg [9:0] msk_ff;
    // ----
    // Helper state
    // ----
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            en_ff <= 1'b0;
            dis_cnt_ff <= 3'h0;
            msk_ff <= 10'h000;
            scl_p_ff <= 1'b1;
            sda_p_ff <= 1'b1;
            seen_ff <= 1'b0;
            last_start_ff <= 1'b0;
            age_ff <= 4'h0;
        end else begin
            scl_p_ff <= scl_in;
            sda_p_ff <= sda_in;
            if (reg_wr && reg_addr == `ISM_A_CTRL)
                en_ff <= reg_wdata[`ISM_C_EN];
            if (en_ff)
                dis_cnt_ff <= 3'h0;
            else if (dis_cnt_ff != 3'h7)
                dis_cnt_ff <= dis_cnt_ff + 3'h1;
            if (reg_wr && reg_addr == `ISM_A_MASK)
                msk_ff <= reg_wdata[9:0];
            // Data edge while clock high is a bus condition
            if (scl_in && scl_p_ff && sda_p_ff != sda_in) begin
                seen_ff <= 1'b1;
                last_start_ff <= !sda_in;
                age_ff <= 4'h0;
            end else if (age_ff != 4'hf)
                age_ff <= age_ff + 4'h1;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    sequence s_sen_trn;
        reg_wr && reg_addr == `ISM_A_CTRL && reg_wdata[0] ##1 reg_wr && reg_addr == `ISM_A_TRN;
    endsequence
    sequence s_rcv_stat;
        reg_rd && reg_addr == `ISM_A_RCV ##1 reg_rd && reg_addr == `ISM_A_STAT;
    endsequence
    sequence s_clr_stat;
        reg_wr && reg_addr == `ISM_A_STAT && reg_wdata[7:6] == 2'b00 ##1 reg_rd && reg_addr == `ISM_A_STAT;
    endsequence
    a_mask_readback: assert property (
        reg_rd && reg_addr == `ISM_A_MASK |=> reg_rdata_ff == {6'h00, msk_ff})
        else $error("mask readback wrong");
    a_cond_flags: assert property (
        reg_rd && reg_addr == `ISM_A_STAT && seen_ff && age_ff > 4'h9
        |=> reg_rdata_ff[4:3] == {!last_start_ff, last_start_ff})
        else $error("start/stop flags wrong");
    a_trn_collide: assert property (
        s_sen_trn ##1 reg_rd && reg_addr == `ISM_A_STAT |=> reg_rdata_ff[7] && !reg_rdata_ff[0])
        else $error("busy write not refused");
    a_rcv_clears: assert property (
        s_rcv_stat |=> !reg_rdata_ff[1])
        else $error("receive full not cleared");
    a_sw_clear: assert property (
        s_clr_stat |=> reg_rdata_ff[7:6] == 2'b00)
        else $error("flag clear failed");
    a_pins_released: assert property (
        dis_cnt_ff == 3'h7 |-> !scl_oe_ff && !sda_oe_ff)
        else $error("pins held while disabled");
    a_start_drive: assert property (
        reg_wr && reg_addr == `ISM_A_CTRL && reg_wdata[15] && reg_wdata[0] && scl_in && sda_in
        |-> ##[1:8] sda_oe_ff)
        else $error("start not driven");
    a_drive_low: assert property (
        scl_out_ff == 1'b0 && sda_out_ff == 1'b0)
        else $error("pin driven high");
endmodule

/* verif/ism_bfm.sv */
// Purpose: Other bus master putting Start, bytes and Stop on the wires.
// Assumes: Open-drain wires with pull-ups; bit time 8 clk_sys cycles.
// Notes:   Clock stands high between frames.
`timescale 1ns/1ns
module ism_bfm (
    input wire clk_sys, // System clock
    input wire sda_w, // Resolved data wire
    output reg scl_low = 1'b0, // Pull clock low
    output reg sda_low = 1'b0 // Pull data low
);
    task tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task start;
        sda_low <= 1'b1;
        tick(4);
        scl_low <= 1'b1;
        tick(4);
    endtask
    // Long low phase: slave lets go of data 5 cycles after a fall
    task put_bit(input bit b, output bit s);
        tick(3);
        sda_low <= !b;
        tick(3);
        scl_low <= 1'b0;
        tick(2);
        s = sda_w;
        scl_low <= 1'b1;
    endtask
    task send_byte(input [7:0] b, output bit ack);
        bit s;
        for (int i = 7; i >= 0; i--)
            put_bit(b[i], s);
        put_bit(1'b1, s);
        ack = !s;
    endtask
    task stop;
        tick(2);
        sda_low <= 1'b1;
        tick(2);
        scl_low <= 1'b0;
        tick(4);
        sda_low <= 1'b0;
        tick(4);
    endtask
endmodule

/* verif/testbench.sv */
// Purpose: Self-checking bench for the two-wire status/mask core.
// Assumes: One other master model on open-drain wires.
// Notes:   Expected flags are worked out here, bytes held in a queue.
`timescale 1ns/1ns
`include "ism_regs.vh"
module testbench;
    reg clk_sys = 1'b0;
    reg sys_rst = 1'b1;
    reg [2:0] reg_addr = 3'h0;
    reg [15:0] reg_wdata = 16'h0000;
    reg reg_wr = 1'b0;
    reg reg_rd = 1'b0;
    wire [15:0] reg_rdata_ff;
    wire scl_oe_ff, sda_oe_ff, scl_low, sda_low;
    wire scl_w = !(scl_oe_ff | scl_low);
    wire sda_w = !(sda_oe_ff | sda_low);
    int failures = 0;
    int compares = 0;
    int n;
    reg [15:0] q, v;
    reg [6:0] own, msk;
    reg [7:0] rx_q[$];
    bit ack;
    always #10 clk_sys = ~clk_sys;
    ism_core #(.HALF_CYC(8)) dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
        .scl_in(scl_w), .sda_in(sda_w), .scl_out_ff(), .scl_oe_ff(scl_oe_ff), .sda_out_ff(),
        .sda_oe_ff(sda_oe_ff));
    ism_bfm bfm (.clk_sys(clk_sys), .sda_w(sda_w), .scl_low(scl_low), .sda_low(sda_low));
    // Read data of the previous cycle is captured before the edge lands
    task cyc(input bit w, input bit r, input [2:0] a, input [15:0] d);
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        q = reg_rdata_ff;
    endtask
    task wr(input [2:0] a, input [15:0] d);
        cyc(1'b1, 1'b0, a, d);
        cyc(1'b0, 1'b0, a, d);
    endtask
    task rd(input [2:0] a);
        cyc(1'b0, 1'b1, a, 16'h0000);
        cyc(1'b0, 1'b0, a, 16'h0000);
    endtask
    task chk(input [15:0] got, input [15:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wait_bit(input [2:0] a, input int b, input bit val);
        n = 0;
        do begin
            rd(a);
            n++;
        end while (q[b] !== val && n < 300);
        chk({15'h0000, q[b]}, {15'h0000, val});
        if (n >= 300)
            finish_test;
    endtask
    task finish_test;
        $display("Counts: %0d compares, %0d failures", compares, failures);
        if (failures == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        n = $urandom(61);
        repeat (6) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rd(`ISM_A_MASK);
        chk(q, 16'h0000);
        rd(3'h7);
        chk(q, 16'h0000);
        repeat (3) begin
            v = $urandom;
            wr(`ISM_A_MASK, v);
            rd(`ISM_A_MASK);
            chk(q, v & 16'h03ff);
        end
        wr(`ISM_A_CTRL, 16'h8000);
        rd(`ISM_A_CTRL);
        chk(q, 16'h8000);
        chk({14'h0000, scl_oe_ff, sda_oe_ff}, 16'h0000);
        $display("Test registers done");
        own = $urandom;
        msk = $urandom & 7'h7e;
        v = $urandom;
        wr(`ISM_A_OWN, {9'h000, own});
        wr(`ISM_A_MASK, {9'h000, msk});
        bfm.start;
        rd(`ISM_A_STAT);
        chk(q & 16'h0018, 16'h0008);
        bfm.send_byte({own ^ (msk & v[6:0]), 1'b0}, ack);
        chk({15'h0000, ack}, 16'h0001);
        rd(`ISM_A_STAT);
        chk(q, 16'h0008);
        repeat (2) begin
            v = $urandom;
            rx_q.push_back(v[7:0]);
            bfm.send_byte(v[7:0], ack);
        end
        chk({15'h0000, ack}, 16'h0000);
        rd(`ISM_A_STAT);
        chk(q, 16'h006a);
        cyc(1'b0, 1'b1, `ISM_A_RCV, 16'h0000);
        cyc(1'b0, 1'b1, `ISM_A_STAT, 16'h0000);
        chk(q, {8'h00, rx_q.pop_front()});
        cyc(1'b1, 1'b0, `ISM_A_STAT, 16'h0000);
        chk(q, 16'h0068);
        rd(`ISM_A_STAT);
        chk(q, 16'h0028);
        bfm.stop;
        rd(`ISM_A_STAT);
        chk(q & 16'h0018, 16'h0010);
        bfm.start;
        bfm.send_byte({own ^ 7'h01, 1'b0}, ack);
        chk({15'h0000, ack}, 16'h0000);
        bfm.stop;
        $display("Test slave done");
        cyc(1'b1, 1'b0, `ISM_A_CTRL, 16'h8001);
        cyc(1'b1, 1'b0, `ISM_A_TRN, 16'h005a);
        rd(`ISM_A_STAT);
        chk(q & 16'h0081, 16'h0080);
        wait_bit(`ISM_A_CTRL, 0, 1'b0);
        wr(`ISM_A_STAT, 16'h0000);
        wr(`ISM_A_TRN, {8'h00, own ^ 7'h01, 1'b0});
        rd(`ISM_A_STAT);
        chk(q & 16'h0081, 16'h0001);
        wait_bit(`ISM_A_STAT, 0, 1'b0);
        wr(`ISM_A_CTRL, 16'h8004);
        wait_bit(`ISM_A_STAT, 4, 1'b1);
        wr(`ISM_A_CTRL, 16'h0000);
        repeat (8) @(posedge clk_sys);
        chk({14'h0000, scl_oe_ff, sda_oe_ff}, 16'h0000);
        $display("Test master done");
        finish_test;
    end
endmodule
bind ism_core ism_props #(.HALF_CYC(HALF_CYC)) u_props (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_ff(reg_rdata_ff), .scl_in(scl_in), .sda_in(sda_in), .scl_out_ff(scl_out_ff),
    .scl_oe_ff(scl_oe_ff), .sda_out_ff(sda_out_ff), .sda_oe_ff(sda_oe_ff));
